// File: core/pkt_builder.sv
// heave and raw measurement payload builder with an ahb-lite register port
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pkt_builder
   import pkt_build_pkg::*;
#(
   parameter int DEPTH = 16, // stored frequency observations
   parameter int SPP = 4, // satellites per raw packet
   parameter bit RAW_EN = 1'b1 // raw packet available on this hardware
) (
   // clock, enable, reset
   input wire logic CLK_I,
   input wire logic CE_I,
   input wire logic RST_B_I,
   // ahb-lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   output logic [31:0] HRDATA_O,
   // payload byte stream
   output logic [7:0] TX_DATA_O,
   output logic TX_VALID_O,
   output logic TX_LAST_O,
   input wire logic TX_READY_I,
   output logic [7:0] PKT_ID_O,
   output logic [15:0] PKT_LEN_O
);
   localparam int IW = $clog2(DEPTH + 1);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rst_sync_q; // release synchroniser
   logic rst_n; // synchronised reset
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      state_t st; // framer state
      logic [NREG-1:0][31:0] rf; // register words
      logic aw; // write data phase pending
      logic [4:0] aidx; // latched word index
      logic [31:0] rdat; // read data
      logic hv_p; // heave request pending
      logic raw_p; // raw request pending
      logic [31:0] sec; // epoch snapshot
      logic [31:0] ns;
      logic [31:0] ofs;
      logic [7:0] rx;
      logic [IW-1:0] e; // next entry to send
      logic [7:0] pno; // packet number
      logic [7:0] tot; // total packets
      logic [7:0] nps; // satellites in this packet
      logic [7:0] sl; // satellites left in packet
      logic [7:0] fl; // frequencies left in satellite
      logic [7:0] done; // satellites sent
      logic [7:0] pid; // packet identifier out
      logic [15:0] plen; // payload length out
   } top_t;
   top_t s_q, s_d;
   // links to the store and shifter
   obs_t wobs, robs;
   logic [IW-1:0] cnt;
   logic [7:0] nsat, span, q_nsat, nps_c, tot_c, left_c;
   logic full, ser_rdy, busy, ld, ld_last;
   logic [REC_W-1:0] ld_dat;
   logic [LEN_W-1:0] ld_len;
   logic acc, map, wr_go, hv_go, raw_go, clr_go, push_go;
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign acc = HSEL_I && HREADY_I && HTRANS_I[1];
   assign map = (HADDR_I[31:7] == '0) && (HADDR_I[6:2] < 5'(NREG));
   assign wr_go = s_q.aw;
   // command pulses come from the write data phase
   assign hv_go = wr_go && s_q.aidx == R_CTRL && HWDATA_I[C_HEAVE];
   assign raw_go = wr_go && s_q.aidx == R_CTRL && HWDATA_I[C_RAW] && RAW_EN;
   assign clr_go = wr_go && s_q.aidx == R_CTRL && HWDATA_I[C_CLEAR] && !busy;
   // pushes wait out a pending or running raw epoch so a split epoch stays whole; the clear waits only for a non-busy framer
   assign push_go = wr_go && s_q.aidx == R_PUSH && !busy && !s_q.raw_p;
   assign busy = (s_q.st != S_IDLE) || !ser_rdy;
   // zero wait states, always okay
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign HRDATA_O = s_q.rdat;
   // ----------------------------------------
   // observation staging with code cleanup
   // ----------------------------------------
   always_comb begin
      wobs.sys = s_q.rf[R_SATID][7:0];
      if (wobs.sys > SYS_LAST) begin
         wobs.sys = SYS_UNKNOWN;
      end
      wobs.prn = s_q.rf[R_SATID][15:8];
      wobs.elev = s_q.rf[R_SATID][23:16];
      wobs.az = s_q.rf[R_AZIM][15:0];
      wobs.code = s_q.rf[R_FREQ][7:0];
      // codes above the third band belong to galileo only
      if (wobs.code > FRQ_GAL_LAST || (wobs.code > FRQ_BAND3 && wobs.sys != SYS_GALILEO)) begin
         wobs.code = FRQ_UNKNOWN;
      end
      // phase, slip, half-cycle, range, doppler, snr flags pass; top two forced low
      wobs.stat = {2'b00, s_q.rf[R_FREQ][8 +: ST_VALID_W]};
      wobs.ph = {s_q.rf[R_PH_HI], s_q.rf[R_PH_LO]};
      wobs.rng = {s_q.rf[R_RG_HI], s_q.rf[R_RG_LO]};
      wobs.dop = s_q.rf[R_DOP];
      wobs.snr = s_q.rf[R_SNR];
   end
   // packet sizing for the epoch
   assign left_c = nsat - s_q.done;
   assign nps_c = (left_c > 8'(SPP)) ? 8'(SPP) : left_c;
   assign tot_c = (nsat == 8'h00) ? 8'h01 : 8'((nsat + 8'(SPP - 1)) / 8'(SPP));
   assign q_nsat = (s_q.st == S_HDR) ? nps_c : 8'h01;
   // ----------------------------------------
   // next state: bus, framer, requests
   // ----------------------------------------
   always_comb begin
      logic [31:0] rd;
      rd = '0;
      s_d = s_q;
      ld = 1'b0;
      ld_dat = '0;
      ld_len = '0;
      ld_last = 1'b0;
      // read mux, forwarding a write still in its data phase
      case (HADDR_I[6:2])
         R_CTRL, R_PUSH: rd = '0;
         R_STATUS: rd = {8'h00, nsat, 8'(cnt), 6'h00, full, busy};
         default: rd = s_q.rf[HADDR_I[6:2]];
      endcase
      // only stored words forward; command words keep reading zero
      if (s_q.aw && s_q.aidx == HADDR_I[6:2] && s_q.aidx >= R_HEAVE0 && s_q.aidx <= R_SNR) begin
         rd = HWDATA_I;
      end
      s_d.aw = acc && HWRITE_I && map;
      if (acc) begin
         s_d.aidx = HADDR_I[6:2];
         s_d.rdat = (!HWRITE_I && map) ? rd : '0; // unmapped reads give zero
      end
      // store plain words; command and status words keep nothing
      if (wr_go && s_q.aidx >= R_HEAVE0 && s_q.aidx <= R_SNR) begin
         s_d.rf[s_q.aidx] = HWDATA_I;
      end
      // framer advances only when the shifter is empty
      if (ser_rdy) begin
         case (s_q.st)
            S_IDLE: begin
               if (s_q.hv_p) begin
                  ld = 1'b1;
                  ld_dat = REC_W'({s_q.rf[R_HEAVE0+3], s_q.rf[R_HEAVE0+2],
                                   s_q.rf[R_HEAVE0+1], s_q.rf[R_HEAVE0]});
                  ld_len = LEN_W'(HEAVE_LEN);
                  ld_last = 1'b1;
                  s_d.pid = HEAVE_ID;
                  s_d.plen = HEAVE_LEN;
                  s_d.hv_p = 1'b0;
               end else if (s_q.raw_p) begin
                  // one timestamp for every packet of the epoch
                  s_d.sec = s_q.rf[R_TSEC];
                  s_d.ns = s_q.rf[R_TNS];
                  s_d.ofs = s_q.rf[R_CLKOFS];
                  s_d.rx = s_q.rf[R_RXNUM][7:0];
                  s_d.e = '0;
                  s_d.pno = 8'h01;
                  s_d.tot = tot_c;
                  s_d.done = '0;
                  s_d.raw_p = 1'b0;
                  s_d.st = S_HDR;
               end
            end
            S_HDR: begin
               ld = 1'b1;
               ld_dat = REC_W'({nps_c, s_q.tot, s_q.pno, s_q.rx,
                                s_q.ofs, s_q.ns, s_q.sec});
               ld_len = LEN_W'(HDR_LEN);
               ld_last = (nps_c == 8'h00);
               s_d.pid = RAW_ID;
               s_d.plen = HDR_LEN + SAT_LEN * 16'(nps_c) + FRQ_LEN * 16'(span);
               s_d.nps = nps_c;
               s_d.sl = nps_c;
               s_d.st = (nps_c == 8'h00) ? S_IDLE : S_SAT;
            end
            S_SAT: begin
               ld = 1'b1;
               ld_dat = REC_W'({span, robs.az, robs.elev, robs.prn, robs.sys});
               ld_len = LEN_W'(SAT_LEN);
               s_d.fl = span;
               s_d.st = S_FRQ;
            end
            S_FRQ: begin
               ld = 1'b1;
               ld_dat = {robs.snr, robs.dop, robs.rng, robs.ph, robs.stat, robs.code};
               ld_len = LEN_W'(FRQ_LEN);
               s_d.e = s_q.e + IW'(1);
               s_d.fl = s_q.fl - 8'h01;
               if (s_q.fl == 8'h01) begin
                  // satellite closed
                  s_d.done = s_q.done + 8'h01;
                  s_d.sl = s_q.sl - 8'h01;
                  s_d.st = S_SAT;
                  if (s_q.sl == 8'h01) begin
                     // packet closed: next header or end of epoch
                     ld_last = 1'b1;
                     s_d.pno = s_q.pno + 8'h01;
                     s_d.st = (s_q.pno == s_q.tot) ? S_IDLE : S_HDR;
                  end
               end
            end
            default: s_d.st = S_IDLE;
         endcase
      end
      // a new request wins over the clear by the framer
      if (hv_go) begin
         s_d.hv_p = 1'b1;
      end
      if (raw_go) begin
         s_d.raw_p = 1'b1;
      end
   end
   // state register, frozen while ce is low
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (CE_I) begin
         s_q <= s_d;
      end
   end
   assign PKT_ID_O = s_q.pid;
   assign PKT_LEN_O = s_q.plen;
   // ----------------------------------------
   // store and shifter
   // ----------------------------------------
   obs_store #(
      .DEPTH(DEPTH),
      .IW(IW)
   ) u_store (
      .clk_i(CLK_I),
      .rst_ni(rst_n),
      .ce_i(CE_I),
      .clr_i(clr_go),
      .push_i(push_go),
      .wdata_i(wobs),
      .rd_idx_i(s_q.e),
      .q_start_i(s_q.e),
      .q_nsat_i(q_nsat),
      .rdata_o(robs),
      .count_o(cnt),
      .nsat_o(nsat),
      .span_o(span),
      .full_o(full)
   );
   lsb_shifter #(
      .NB(REC_W / 8)
   ) u_shift (
      .clk_i(CLK_I),
      .rst_ni(rst_n),
      .ce_i(CE_I),
      .ld_i(ld),
      .data_i(ld_dat),
      .len_i(ld_len),
      .last_i(ld_last),
      .rdy_o(ser_rdy),
      .byte_o(TX_DATA_O),
      .valid_o(TX_VALID_O),
      .last_o(TX_LAST_O),
      .take_i(TX_READY_I)
   );
   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [15:0] bcnt_q; // bytes of the current payload sent
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         bcnt_q <= '0;
      end else if (CE_I && TX_VALID_O && TX_READY_I) begin
         bcnt_q <= TX_LAST_O ? 16'h0000 : bcnt_q + 16'h0001;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!rst_n);
   sequence heave_load_s;
      CE_I && ld && s_q.st == S_IDLE && s_q.hv_p;
   endsequence
   payload_len_a: assert property (CE_I && TX_VALID_O && TX_READY_I && TX_LAST_O
      |-> bcnt_q + 16'h0001 == PKT_LEN_O) else $error("payload length mismatch");
   heave_id_a: assert property (heave_load_s
      |=> PKT_ID_O == HEAVE_ID && PKT_LEN_O == HEAVE_LEN) else $error("heave id wrong");
   raw_id_a: assert property (CE_I && ser_rdy && s_q.st == S_HDR
      |=> PKT_ID_O == RAW_ID) else $error("raw id wrong");
   seq_range_a: assert property (s_q.st != S_IDLE
      |-> s_q.pno >= 8'h01 && s_q.pno <= s_q.tot) else $error("sequence out of range");
   sys_code_a: assert property (ld && s_q.st == S_SAT
      |-> ld_dat[7:0] <= SYS_LAST && ld_dat[47:40] != 8'h00) else $error("bad system");
   freq_code_a: assert property (ld && s_q.st == S_FRQ
      |-> ld_dat[7:0] <= FRQ_BAND3 || robs.sys == SYS_GALILEO) else $error("bad freq code");
   stat_rsv_a: assert property (ld && s_q.st == S_FRQ
      |-> ld_dat[8+ST_RSV_LO +: 2] == 2'b00) else $error("reserved status set");
   stamp_hold_a: assert property (CE_I && s_q.st != S_IDLE && s_d.st != S_IDLE
      |=> $stable(s_q.sec) && $stable(s_q.ns)) else $error("timestamp moved");
   hdr_time_a: assert property (ld && s_q.st == S_HDR
      |-> ld_dat[31:0] == s_q.sec && ld_dat[95:64] == s_q.ofs) else $error("header time");
endmodule
`default_nettype wire

// File: inc/pkt_build_pkg.sv
// constants and types for the heave and raw measurement packet builder
// Operation
// - heave packet id 58, four fp32, 16 bytes
// - raw packet id 60, first generation only
// - raw length 16 plus 6+26*freqs per satellite
// - header sec, nanoseconds, signed clock offset
// - header receiver, sequence, total, satellite count bytes
// - satellite record system, number, elevation, azimuth, count
// - frequency record code, status, phase, range, doppler, snr
// - system codes 0..6, 7..9 never generated
// - frequency codes per system, 9,10 Galileo only
// - status bits 0..2 carrier phase flags
// - status bits 3..5 range, doppler, snr valid
// - status bits 6..7 always zero
`default_nettype none
package pkt_build_pkg;
   // ----------------------------------------
   // packet identity and sizes
   // ----------------------------------------
   localparam logic [7:0] HEAVE_ID = 8'h3a;
   localparam logic [7:0] RAW_ID = 8'h3c;
   localparam logic [15:0] HEAVE_LEN = 16'h0010;
   localparam logic [15:0] HDR_LEN = 16'h0010;
   localparam logic [15:0] SAT_LEN = 16'h0006;
   localparam logic [15:0] FRQ_LEN = 16'h001a;
   localparam int REC_W = 208;
   localparam int LEN_W = 5;
   // ----------------------------------------
   // code tables
   // ----------------------------------------
   localparam logic [7:0] SYS_UNKNOWN = 8'h00;
   localparam logic [7:0] SYS_GALILEO = 8'h04;
   localparam logic [7:0] SYS_LAST = 8'h06;
   localparam logic [7:0] FRQ_UNKNOWN = 8'h00;
   localparam logic [7:0] FRQ_BAND3 = 8'h08;
   localparam logic [7:0] FRQ_GAL_LAST = 8'h0a;
   localparam int ST_VALID_W = 6;
   localparam int ST_RSV_LO = 6;
   // ----------------------------------------
   // register word indices, byte address = 4 * index
   // ----------------------------------------
   localparam logic [4:0] R_CTRL = 5'h00;
   localparam logic [4:0] R_STATUS = 5'h01;
   localparam logic [4:0] R_HEAVE0 = 5'h02;
   localparam logic [4:0] R_TSEC = 5'h06;
   localparam logic [4:0] R_TNS = 5'h07;
   localparam logic [4:0] R_CLKOFS = 5'h08;
   localparam logic [4:0] R_RXNUM = 5'h09;
   localparam logic [4:0] R_SATID = 5'h0a;
   localparam logic [4:0] R_AZIM = 5'h0b;
   localparam logic [4:0] R_FREQ = 5'h0c;
   localparam logic [4:0] R_PH_LO = 5'h0d;
   localparam logic [4:0] R_PH_HI = 5'h0e;
   localparam logic [4:0] R_RG_LO = 5'h0f;
   localparam logic [4:0] R_RG_HI = 5'h10;
   localparam logic [4:0] R_DOP = 5'h11;
   localparam logic [4:0] R_SNR = 5'h12;
   localparam logic [4:0] R_PUSH = 5'h13;
   localparam int NREG = 20;
   // control bits
   localparam int C_HEAVE = 0;
   localparam int C_RAW = 1;
   localparam int C_CLEAR = 2;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_HDR = 2'b01,
      S_SAT = 2'b11,
      S_FRQ = 2'b10
   } state_t;
   typedef struct packed {
      logic [31:0] snr;
      logic [31:0] dop;
      logic [63:0] rng;
      logic [63:0] ph;
      logic [7:0] stat;
      logic [7:0] code;
      logic [15:0] az;
      logic [7:0] elev;
      logic [7:0] prn;
      logic [7:0] sys;
   } obs_t;
endpackage
`default_nettype wire

// File: core/lsb_shifter.sv
// byte shifter that sends a loaded record least significant byte first
`timescale 1ns/1ns
`default_nettype none
module lsb_shifter
   import pkt_build_pkg::*;
#(
   parameter int NB = 26
) (
   // clock and control
   input wire logic clk_i,
   input wire logic rst_ni,
   input wire logic ce_i,
   // load side
   input wire logic ld_i,
   input wire logic [NB*8-1:0] data_i,
   input wire logic [LEN_W-1:0] len_i,
   input wire logic last_i,
   output logic rdy_o,
   // byte side
   output logic [7:0] byte_o,
   output logic valid_o,
   output logic last_o,
   input wire logic take_i
);
   typedef struct packed {
      logic [NB*8-1:0] sh; // bytes still to send
      logic [LEN_W-1:0] cnt; // bytes left
      logic lst; // record closes the packet
   } sh_t;
   sh_t s_q, s_d;
   // ----------------------------------------
   // handshake
   // ----------------------------------------
   assign rdy_o = (s_q.cnt == '0);
   assign valid_o = !rdy_o;
   assign byte_o = s_q.sh[7:0];
   assign last_o = s_q.lst && (s_q.cnt == LEN_W'(1));
   // next state: shift right so byte 0 goes first
   always_comb begin
      s_d = s_q;
      if (ld_i && rdy_o) begin
         s_d.sh = data_i;
         s_d.cnt = len_i;
         s_d.lst = last_i;
      end else if (valid_o && take_i) begin
         s_d.sh = s_q.sh >> 8;
         s_d.cnt = s_q.cnt - LEN_W'(1);
      end
   end
   // state register, frozen while ce is low
   always_ff @(posedge clk_i or negedge rst_ni) begin
      if (!rst_ni) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
   lsb_first_a: assert property (@(posedge clk_i) disable iff (!rst_ni)
      ce_i && valid_o && take_i && s_q.cnt > LEN_W'(1) |=> byte_o == $past(s_q.sh[15:8]))
      else $error("byte order is not lsb first");
endmodule
`default_nettype wire

// File: core/obs_store.sv
// flip-flop store of frequency observations, grouped by satellite
`timescale 1ns/1ns
`default_nettype none
module obs_store
   import pkt_build_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int IW = 5
) (
   // clock and control
   input wire logic clk_i,
   input wire logic rst_ni,
   input wire logic ce_i,
   // write side
   input wire logic clr_i,
   input wire logic push_i,
   input wire obs_t wdata_i,
   // read and query side
   input wire logic [IW-1:0] rd_idx_i,
   input wire logic [IW-1:0] q_start_i,
   input wire logic [7:0] q_nsat_i,
   output obs_t rdata_o,
   output logic [IW-1:0] count_o,
   output logic [7:0] nsat_o,
   output logic [7:0] span_o,
   output logic full_o
);
   typedef struct packed {
      obs_t [DEPTH-1:0] mem; // entries
      logic [IW-1:0] cnt; // fill level
   } st_t;
   st_t s_q, s_d;
   logic [DEPTH-1:0] first; // entry opens a new satellite
   // ----------------------------------------
   // satellite boundaries
   // ----------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_first
      if (i == 0) begin : g_head
         assign first[i] = 1'b1;
      end else begin : g_rest
         assign first[i] = (s_q.mem[i].sys != s_q.mem[i-1].sys) ||
                           (s_q.mem[i].prn != s_q.mem[i-1].prn);
      end
   end
   assign rdata_o = s_q.mem[rd_idx_i];
   assign count_o = s_q.cnt;
   assign full_o = (s_q.cnt == IW'(DEPTH));
   // satellite count and frequencies covered by q_nsat satellites from q_start
   always_comb begin
      logic [7:0] ns;
      logic [7:0] seen;
      logic [7:0] nf;
      ns = '0;
      seen = '0;
      nf = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (IW'(i) < s_q.cnt) begin
            if (first[i]) begin
               ns = ns + 8'h01;
            end
            if (IW'(i) >= q_start_i) begin
               if (first[i]) begin
                  seen = seen + 8'h01;
               end
               if (seen <= q_nsat_i) begin
                  nf = nf + 8'h01;
               end
            end
         end
      end
      nsat_o = ns;
      span_o = nf;
   end
   // fill: clear wins, a push into a full store is dropped
   always_comb begin
      s_d = s_q;
      if (clr_i) begin
         s_d.cnt = '0;
      end else if (push_i && !full_o) begin
         s_d.mem[s_q.cnt] = wdata_i;
         s_d.cnt = s_q.cnt + IW'(1);
      end
   end
   always_ff @(posedge clk_i or negedge rst_ni) begin
      if (!rst_ni) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// File: tb/host_sink.sv
// payload sink standing in for the receiving host
`timescale 1ns/1ns
`default_nettype none
module host_sink (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_ni,
   // byte stream
   input wire logic slow_i,
   output logic ready_o
);
   // ready moves only after an edge; slow mode stalls most cycles
   always @(posedge clk_i or negedge rst_ni) begin
      if (!rst_ni) begin
         ready_o <= 1'b0;
      end else begin
         // ready drawn at random: high one cycle in four in slow mode, three in four otherwise
         ready_o <= slow_i ? ($urandom % 4 == 0) : ($urandom % 4 != 0);
      end
   end
endmodule
`default_nettype wire

// File: tb/pkt_builder_test.sv
// self-checking bench for the payload builder
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected %0t got %h want %h", $time, a, b); end end
module pkt_builder_test
   import pkt_build_pkg::*;
;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 1'b0, rst_b = 1'b0, slow = 1'b0, rdy, hready, hresp, txv, txl, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, tsec, tns, cofs, r;
   logic [1:0] htrans = 2'h0;
   logic ce = 1'b1; // clock enable, stalled only while the bus is quiet
   logic [7:0] txd, pid, cid, rx;
   logic [15:0] plen, clen;
   logic [32:0] q[$], e; // notes: last, id, length, byte
   logic [255:0] rv;
   logic [31:0] h [4];
   obs_t o [3];
   int err_total = 0, total_checks = 0, cyc = 0;
   always #2 clk = ~clk;
   // one satellite per packet so two satellites force a split
   pkt_builder #(.SPP(1)) DUT (.CLK_I(clk), .CE_I(ce), .RST_B_I(rst_b), .HSEL_I(1'b1),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .HRDATA_O(hrdata), .TX_DATA_O(txd), .TX_VALID_O(txv), .TX_LAST_O(txl),
      .TX_READY_I(rdy), .PKT_ID_O(pid), .PKT_LEN_O(plen));
   host_sink SINK (.clk_i(clk), .rst_ni(rst_b), .slow_i(slow), .ready_o(rdy));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // single word transfer; waits on hready, bounded by the cycle ceiling
   task automatic ahb(input logic w, input logic [4:0] i, input logic [31:0] d);
      @(posedge clk);
      haddr <= {25'h0, i, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [4:0] i, input logic [31:0] x);
      ahb(1'b0, i, 32'h0);
      `CHK({hresp, r}, {1'b0, x})
   endtask
   // note n bytes of a field, lowest byte first
   task automatic put(input logic [255:0] v, input int n);
      for (int k = 0; k < n; k++) q.push_back({1'b0, cid, clen, v[8*k+:8]});
   endtask
   // stage one observation; reserved status bits are written high on purpose
   task automatic push(input obs_t x);
      ahb(1'b1, R_SATID, {8'h00, x.elev, x.prn, x.sys});
      ahb(1'b1, R_AZIM, {16'h0, x.az});
      ahb(1'b1, R_FREQ, {16'h0, 2'b11, x.stat[5:0], x.code});
      ahb(1'b1, R_PH_LO, x.ph[31:0]);
      ahb(1'b1, R_PH_HI, x.ph[63:32]);
      ahb(1'b1, R_RG_LO, x.rng[31:0]);
      ahb(1'b1, R_RG_HI, x.rng[63:32]);
      ahb(1'b1, R_DOP, x.dop);
      ahb(1'b1, R_SNR, x.snr);
      ahb(1'b1, R_PUSH, 32'h0);
   endtask
   // notes for raw packet k holding nf entries from index a
   task automatic pkt(input int k, input int a, input int nf);
      cid = 8'h3c;
      clen = 16'h0016 + 16'(26 * nf);
      put(256'({8'h01, 8'h02, 8'(k), rx, cofs, tns, tsec}), 16);
      put(256'({8'(nf), o[a].az, o[a].elev, o[a].prn, o[a].sys}), 6);
      for (int f = a; f < a + nf; f++) begin
         put(256'({o[f].snr, o[f].dop, o[f].rng, o[f].ph,
                   2'b00, o[f].stat[5:0], o[f].code}), 26);
      end
      q[$][32] = 1'b1;
   endtask
   // ----------------------------------------
   // byte checker and cycle ceiling
   // ----------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (txv === 1'b1 && rdy === 1'b1 && ce === 1'b1) begin
         if (q.size() == 0) begin
            `CHK(1'b1, 1'b0)
         end else begin
            e = q.pop_front();
            `CHK({txl, pid, plen, txd}, e)
         end
      end
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h4ad1bcb9));
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      tsec = $urandom;
      tns = $urandom;
      cofs = $urandom;
      rx = 8'($urandom);
      for (int i = 0; i < 4; i++) begin
         h[i] = $urandom;
         ahb(1'b1, 5'(R_HEAVE0 + 5'(i)), h[i]);
      end
      ahb(1'b1, R_TSEC, tsec);
      ahb(1'b1, R_TNS, tns);
      ahb(1'b1, R_CLKOFS, cofs);
      ahb(1'b1, R_RXNUM, {24'h0, rx});
      // two entries of one galileo satellite, one of a reserved system
      for (int i = 0; i < 3; i++) begin
         rv = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
         o[i] = rv[247:0];
         o[i].sys = (i < 2) ? 8'h04 : 8'h09;
         o[i].prn = 8'(i / 2 + 1);
         o[i].code = (i == 0) ? 8'h0a : 8'h09;
         push(o[i]);
      end
      o[2].sys = 8'h00;
      o[2].code = 8'h00;
      rd(R_STATUS, 32'h00020300);
      rd(5'h1f, 32'h0);
      cid = 8'h3a;
      clen = 16'h0010;
      for (int i = 0; i < 4; i++) put({224'h0, h[i]}, 4);
      q[$][32] = 1'b1;
      pkt(1, 0, 2);
      pkt(2, 2, 1);
      // raw request lands while the heave payload is still going out
      ahb(1'b1, R_CTRL, 32'h1);
      ahb(1'b1, R_CTRL, 32'h2);
      while (q.size() > 60) @(posedge clk);
      slow <= 1'b1;
      // random enable stalls during the drain; a bus write would be lost while it is low
      while (q.size() > 0) begin
         ce <= ($urandom % 4 != 0);
         @(posedge clk);
      end
      ce <= 1'b1;
      slow <= 1'b0;
      ahb(1'b1, R_CTRL, 32'h4);
      rd(R_STATUS, 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
